// ===== inc/smi_source_status_defs.svh
`ifndef SMI_SOURCE_STATUS_DEFS_SVH
`define SMI_SOURCE_STATUS_DEFS_SVH

// ========================================
// register map
`define CAUSE_STATUS_OFS 16'h0034
`define PM1_CTRL_OFS 16'h0004
`define MICRO_PORT_LO 16'h0062
`define MICRO_PORT_HI 16'h0066
`define SLEEP_EN_BIT 13
`define GLB_RELEASE_BIT 2
`define CAUSE_RESET 32'h0000_0000
`define END_SMI_RESET 1'b1

// ========================================
// field positions
`define B_USB3 31
`define B_ENGINE 30
`define B_ESPI 28
`define B_UNLOCK 27
`define B_FLASH 26
`define B_MONITOR 21
`define B_PCIE 20
`define B_SMBUS 16
`define B_SERIRQ 15
`define B_PERIODIC 14
`define B_TCO 13
`define B_DEVMON 12
`define B_MICRO 11
`define B_PIN 10
`define B_GPE 9
`define B_PM1 8
`define B_SWTMR 6
`define B_APM 5
`define B_SLEEP 4
`define B_LEGACY 3
`define B_RELEASE 2

// ========================================
// masks
`define W1C_MASK 32'h0801_6874
`define CAUSE_MASK 32'hDC31_F87C
`define RSVD_MASK 32'h23CE_0083
`define GPE_SUMMARY_MASK 32'h0007_2D04
`define PM1_SUMMARY_MASK 16'hFFCF
`define LEGACY_KBD_W 8

// ========================================
// timing
`define CLK_PERIOD_NS 4
`define PCI_CLK_NS 30
`define PCI_DIV_CYC ((`PCI_CLK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SMI_GAP_PCI 4
`define PERIODIC_BASE_MS 8
`define PERIODIC_BASE_CYC (`PERIODIC_BASE_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ===== inc/smi_source_status_pkg.sv
package smi_source_status_pkg;
   typedef enum logic [1:0] {ARB_IDLE, ARB_ACTIVE, ARB_GAP} arb_state_t;
   typedef logic [31:0] cause_word_t;
endpackage

// ===== inc/smi_req_if.sv
`timescale 1ns/1ps
interface smi_req_if;
   logic pending;
   logic globalEnable;
   logic endSmiSet;
   logic endSmi;
   logic irqN;
   modport arb (
      input  pending,
      input  globalEnable,
      input  endSmiSet,
      output endSmi,
      output irqN
   );
   modport src (
      output pending,
      output globalEnable,
      output endSmiSet,
      input  endSmi,
      input  irqN
   );
endinterface

// ===== core/smi_arbiter.sv
`timescale 1ns/1ps
`include "smi_source_status_defs.svh"
module smi_arbiter
   import smi_source_status_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   smi_req_if.arb   req
);
   // ========================================
   // state
   localparam int GAP_CYC = `SMI_GAP_PCI * `PCI_DIV_CYC;

   arb_state_t state_ff;
   arb_state_t nxt_state;
   logic [3:0] divCnt_ff;
   logic [2:0] gapCnt_ff;
   logic       endSmi_ff;
   logic       irqN_ff;

   wire inGap   = (state_ff == ARB_GAP);
   wire pciTick = inGap && (divCnt_ff == 4'(`PCI_DIV_CYC - 1));
   wire gapDone = pciTick && (gapCnt_ff == 3'(`SMI_GAP_PCI - 1));
   wire fire    = (state_ff == ARB_IDLE) && req.pending
                  && req.globalEnable && endSmi_ff;
   wire nxt_endSmi = req.endSmiSet | (endSmi_ff & ~fire);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ARB_IDLE:   if (fire) nxt_state = ARB_ACTIVE;
         ARB_ACTIVE: if (endSmi_ff) nxt_state = ARB_GAP;
         ARB_GAP:    if (gapDone) nxt_state = ARB_IDLE;
         default:    nxt_state = ARB_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= ARB_IDLE;
         endSmi_ff <= `END_SMI_RESET;
         irqN_ff  <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         endSmi_ff <= nxt_endSmi;
         irqN_ff  <= (nxt_state != ARB_ACTIVE);
      end
   end

   // pci-rate divider runs only during the gap so the gap is whole periods
   always_ff @(posedge clk) begin
      if (reset || !inGap) begin
         divCnt_ff <= 4'h0;
         gapCnt_ff <= 3'h0;
      end else if (pciTick) begin
         divCnt_ff <= 4'h0;
         gapCnt_ff <= gapCnt_ff + 3'h1;
      end else begin
         divCnt_ff <= divCnt_ff + 4'h1;
      end
   end

   assign req.endSmi = endSmi_ff;
   assign req.irqN = irqN_ff;

   // ========================================
   // checks
   logic [5:0] hiCnt_ff;
   logic       seenLow_ff;
   always_ff @(posedge clk) begin
      if (reset) begin
         hiCnt_ff   <= 6'h00;
         seenLow_ff <= 1'b0;
      end else begin
         if (!irqN_ff) seenLow_ff <= 1'b1;
         if (!irqN_ff) hiCnt_ff <= 6'h00;
         else if (hiCnt_ff != 6'h3F) hiCnt_ff <= hiCnt_ff + 6'h01;
      end
   end

   endsmi_autoclear_a: assert property (
      @(posedge clk) disable iff (reset)
      $fell(irqN_ff) && !$past(req.endSmiSet) |-> !endSmi_ff)
      else $error("end of smi not cleared on assertion");

   needs_endsmi_a: assert property (
      @(posedge clk) disable iff (reset)
      $fell(irqN_ff) |-> $past(endSmi_ff))
      else $error("smi asserted without end of smi");

   gap_width_a: assert property (
      @(posedge clk) disable iff (reset)
      $fell(irqN_ff) && seenLow_ff |-> int'(hiCnt_ff) > GAP_CYC)
      else $error("inactive gap too short");

   global_off_a: assert property (
      @(posedge clk) disable iff (reset)
      state_ff == ARB_IDLE && !req.globalEnable |=> irqN_ff)
      else $error("smi with global enable clear");
endmodule

// ===== core/smi_source_status.sv
`timescale 1ns/1ps
`include "smi_source_status_defs.svh"
module smi_source_status
   import smi_source_status_pkg::*;
#(
   parameter int unsigned PERIODIC_BASE_CYC = `PERIODIC_BASE_CYC
)
(
   input  wire logic                     clk,
   input  wire logic                     reset,
   // i/o space access
   input  wire logic [15:0]              acpiBase,
   input  wire logic [15:0]              ioAddr,
   input  wire logic                     ioWrStrobe,
   input  wire logic                     ioRdStrobe,
   input  wire logic [3:0]               ioByteEn,
   input  wire logic [31:0]              ioWrData,
   output wire logic [31:0]              ioRdData,
   output wire logic                     ioRdValid,
   // enables held in the control register
   input  wire logic [31:0]              smiEnable,
   input  wire logic                     globalSmiEnable,
   input  wire logic                     endSmiSetPulse,
   output wire logic                     endOfSmi,
   output wire logic                     sysMgmtIrqN,
   // level sources
   input  wire logic                     usb3HostSmiReq,
   input  wire logic                     engineSmiReq,
   input  wire logic                     serialFlashSmiReq,
   input  wire logic                     trapMonitorReq,
   input  wire logic                     pcieSmiReq,
   input  wire logic                     serialIrqSmiReq,
   input  wire logic                     deviceTrapStatus0,
   input  wire logic                     pinSmiReq,
   input  wire logic [31:0]              gpeStatus,
   input  wire logic [31:0]              gpeEnable,
   input  wire logic [15:0]              pm1Status,
   input  wire logic [`LEGACY_KBD_W-1:0] legacyKbdStatus,
   input  wire logic [`LEGACY_KBD_W-1:0] legacyKbdEnable,
   // event sources
   input  wire logic                     espiSmiAssert,
   input  wire logic                     espiSmiDeassert,
   input  wire logic                     pinUnlockSmiReq,
   input  wire logic                     tcoSmiEvent,
   input  wire logic                     softTimerExpire,
   input  wire logic                     apmCtrlWrite,
   input  wire logic [1:0]               periodicRateSelect,
   // smbus
   input  wire logic                     smbusTargetSmiMsg,
   input  wire logic                     smbusHostNotifyMsg,
   input  wire logic                     smbusSmiInS0Msg,
   input  wire logic                     smbusAlertN,
   input  wire logic                     smbusSmiEnable,
   input  wire logic                     smbusAlertDisable,
   input  wire logic                     hostNotifyIrqEnable
);
   // ========================================
   // address decode
   function automatic logic ioHit(
      input logic [15:0] addr,
      input logic [15:0] target
   );
      return addr == target;
   endfunction

   wire [15:0] causeAddr = acpiBase + `CAUSE_STATUS_OFS;
   wire [15:0] pm1Addr   = acpiBase + `PM1_CTRL_OFS;
   wire        anyAccess = ioRdStrobe | ioWrStrobe;

   wire rdHit   = ioRdStrobe & ioHit(ioAddr, causeAddr);
   wire causeWr = ioWrStrobe & ioHit(ioAddr, causeAddr);
   wire pm1Wr   = ioWrStrobe & ioHit(ioAddr, pm1Addr);

   wire microHit = anyAccess
                   & (ioHit(ioAddr, `MICRO_PORT_LO)
                   | ioHit(ioAddr, `MICRO_PORT_HI));

   wire sleepWr = pm1Wr & ioByteEn[1]
                  & ioWrData[`SLEEP_EN_BIT];
   wire releaseWr = pm1Wr & ioByteEn[0]
                    & ioWrData[`GLB_RELEASE_BIT];

   // ========================================
   // byte lanes
   logic [31:0] wrMask;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wrMask[gi*8 +: 8] = {8{ioByteEn[gi]}};
      end
   endgenerate

   // only the write-1-clear bits react to writes
   wire [31:0] stickyClr = causeWr
                           ? (ioWrData & wrMask & `W1C_MASK)
                           : 32'h0000_0000;

   // ========================================
   // smbus alert pin
   logic alertSync1_ff;
   logic alertSync2_ff;
   logic alertPrev_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         alertSync1_ff <= 1'b1;
         alertSync2_ff <= 1'b1;
         alertPrev_ff  <= 1'b1;
      end else begin
         alertSync1_ff <= smbusAlertN;
         alertSync2_ff <= alertSync1_ff;
         alertPrev_ff  <= alertSync2_ff;
      end
   end

   wire alertFall = alertPrev_ff & ~alertSync2_ff;

   wire smbusAlertHit = alertFall & smbusSmiEnable
                        & ~smbusAlertDisable;
   wire smbusNotifyHit = smbusHostNotifyMsg
                         & hostNotifyIrqEnable
                         & smbusSmiEnable;
   wire smbusSet = smbusTargetSmiMsg | smbusAlertHit
                   | smbusNotifyHit | smbusSmiInS0Msg;

   // ========================================
   // periodic source
   logic [31:0] perCnt_ff;
   wire  [31:0] perLimit = (PERIODIC_BASE_CYC << periodicRateSelect)
                           - 32'd1;
   // >= so that lowering periodicRateSelect mid-count cannot miss the wrap
   wire periodicTick = (perCnt_ff >= perLimit);

   always_ff @(posedge clk) begin
      if (reset || periodicTick) perCnt_ff <= 32'h0000_0000;
      else perCnt_ff <= perCnt_ff + 32'd1;
   end

   // ========================================
   // sticky bits
   logic [31:0] stickySet;
   logic [31:0] sticky_ff;

   always_comb begin
      stickySet = 32'h0000_0000;
      stickySet[`B_UNLOCK]   = pinUnlockSmiReq;
      stickySet[`B_SMBUS]    = smbusSet;
      stickySet[`B_PERIODIC] = periodicTick;
      stickySet[`B_TCO]      = tcoSmiEvent;
      stickySet[`B_MICRO]    = microHit;
      stickySet[`B_SWTMR]    = softTimerExpire;
      stickySet[`B_APM]      = apmCtrlWrite
                               & smiEnable[`B_APM];
      stickySet[`B_SLEEP]    = sleepWr;
      stickySet[`B_RELEASE]  = releaseWr;
   end

   // a set in the cycle of its clear wins
   wire [31:0] nxt_sticky = (stickySet | (sticky_ff & ~stickyClr))
                            & `W1C_MASK;

   always_ff @(posedge clk) begin
      if (reset) sticky_ff <= `CAUSE_RESET;
      else sticky_ff <= nxt_sticky;
   end

   // ========================================
   // espi flag
   logic espi_ff;
   wire  nxt_espi = espiSmiAssert | (espi_ff & ~espiSmiDeassert);

   always_ff @(posedge clk) begin
      if (reset) espi_ff <= 1'b0;
      else espi_ff <= nxt_espi;
   end

   // ========================================
   // status word
   wire gpeSummary = |(gpeStatus & gpeEnable
                      & `GPE_SUMMARY_MASK);
   wire pm1Summary = |(pm1Status & `PM1_SUMMARY_MASK);
   wire legacySummary = |(legacyKbdStatus
                         & legacyKbdEnable);

   cause_word_t status;
   always_comb begin
      status = sticky_ff;
      status[`B_USB3]    = usb3HostSmiReq;
      status[`B_ENGINE]  = engineSmiReq;
      status[`B_ESPI]    = espi_ff;
      status[`B_FLASH]   = serialFlashSmiReq;
      status[`B_MONITOR] = trapMonitorReq;
      status[`B_PCIE]    = pcieSmiReq;
      status[`B_SERIRQ]  = serialIrqSmiReq;
      status[`B_DEVMON]  = deviceTrapStatus0;
      status[`B_PIN]     = pinSmiReq;
      status[`B_GPE]     = gpeSummary;
      status[`B_PM1]     = pm1Summary;
      status[`B_LEGACY]  = legacySummary;
      status = status & ~`RSVD_MASK;
   end

   // ========================================
   // read port
   logic [31:0] ioRdData_ff;
   logic        ioRdValid_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         ioRdData_ff  <= 32'h0000_0000;
         ioRdValid_ff <= 1'b0;
      end else begin
         ioRdValid_ff <= rdHit;
         if (rdHit) ioRdData_ff <= status;
      end
   end

   assign ioRdData  = ioRdData_ff;
   assign ioRdValid = ioRdValid_ff;

   // ========================================
   // smi request
   smi_req_if reqBus ();

   // gpio, gpe and pm1 summaries are outside the cause mask
   assign reqBus.pending = |(status & smiEnable
                            & `CAUSE_MASK);
   assign reqBus.globalEnable = globalSmiEnable;
   assign reqBus.endSmiSet = endSmiSetPulse;

   smi_arbiter u_arbiter (
      .clk   (clk),
      .reset (reset),
      .req   (reqBus)
   );

   assign sysMgmtIrqN = reqBus.irqN;
   assign endOfSmi    = reqBus.endSmi;

   // ========================================
   // checks
   rd_usb3_a: assert property (
      @(posedge clk) disable iff (reset)
      rdHit |=> ioRdData_ff[`B_USB3] == $past(usb3HostSmiReq))
      else $error("usb3 bit wrong on read");

   espi_set_a: assert property (
      @(posedge clk) disable iff (reset)
      espiSmiAssert |=> espi_ff)
      else $error("espi flag not set");

   espi_hold_a: assert property (
      @(posedge clk) disable iff (reset)
      espi_ff && !espiSmiDeassert |=> espi_ff)
      else $error("espi flag dropped early");

   unlock_clear_a: assert property (
      @(posedge clk) disable iff (reset)
      causeWr && ioByteEn[3] && ioWrData[`B_UNLOCK]
      && !pinUnlockSmiReq |=> !sticky_ff[`B_UNLOCK])
      else $error("unlock flag not cleared");

   smbus_alert_a: assert property (
      @(posedge clk) disable iff (reset)
      smbusAlertHit |=> sticky_ff[`B_SMBUS])
      else $error("smbus flag not set by alert");

   micro_trap_a: assert property (
      @(posedge clk) disable iff (reset)
      microHit |=> sticky_ff[`B_MICRO])
      else $error("micro range access missed");

   timer_sticky_a: assert property (
      @(posedge clk) disable iff (reset)
      sticky_ff[`B_SWTMR] && !stickyClr[`B_SWTMR]
      |=> sticky_ff[`B_SWTMR])
      else $error("timer flag lost");

   release_set_a: assert property (
      @(posedge clk) disable iff (reset)
      releaseWr |=> sticky_ff[`B_RELEASE])
      else $error("release write missed");

   rsvd_zero_a: assert property (
      @(posedge clk) disable iff (reset)
      ioRdValid_ff |-> (ioRdData_ff & `RSVD_MASK) == 32'h0)
      else $error("reserved bit reads one");
endmodule

// ===== verification/host_smi_model.sv
`timescale 1ns/1ps
// ========================================
// host side: services each smi after a delay by pulsing end-of-smi
module host_smi_model #(
   parameter int SERVICE_CYC = 6
)
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic sysMgmtIrqN,
   input  wire logic serviceEn,
   output logic      endSmiSetPulse,
   output int        lowCount,
   output int        minGap
);
   int lowCyc;
   int highCyc;
   initial endSmiSetPulse = 1'b0;
   // inputs change at the falling edge, away from the design's sampling edge
   always @(negedge clk) begin
      // a slow host simply holds serviceEn low; service starts once it is raised
      endSmiSetPulse <= !reset && sysMgmtIrqN === 1'b0 && serviceEn && lowCyc >= SERVICE_CYC;
      if (reset) begin
         lowCyc   <= 0;
         highCyc  <= 0;
         lowCount <= 0;
         minGap   <= 1000;
      end else if (sysMgmtIrqN === 1'b0) begin
         if (lowCyc == 0 && lowCount > 0 && highCyc < minGap) begin
            minGap <= highCyc;
         end
         if (lowCyc == 0) begin
            lowCount <= lowCount + 1;
         end
         lowCyc  <= lowCyc + 1;
         highCyc <= 0;
      end else begin
         lowCyc  <= 0;
         highCyc <= highCyc + 1;
      end
   end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`include "smi_source_status_defs.svh"
module tb_top
   import smi_source_status_pkg::*;
;
   logic clk, reset, ioWrStrobe, ioRdStrobe, globalSmiEnable, serviceEn;
   logic [15:0] acpiBase, ioAddr, pm1Status;
   logic [3:0] ioByteEn;
   logic [31:0] ioWrData, smiEnable, gpeStatus, gpeEnable;
   logic usb3HostSmiReq, engineSmiReq, serialFlashSmiReq, trapMonitorReq, pcieSmiReq, serialIrqSmiReq;
   logic deviceTrapStatus0, pinSmiReq, espiSmiAssert, espiSmiDeassert, pinUnlockSmiReq, tcoSmiEvent;
   logic softTimerExpire, apmCtrlWrite, smbusTargetSmiMsg, smbusHostNotifyMsg, smbusSmiInS0Msg;
   logic smbusAlertN, smbusSmiEnable, smbusAlertDisable, hostNotifyIrqEnable;
   logic [7:0] legacyKbdStatus, legacyKbdEnable;
   logic [1:0] periodicRateSelect;
   wire logic [31:0] ioRdData;
   wire logic ioRdValid, endOfSmi, sysMgmtIrqN, endSmiSetPulse;
   int lowCount, minGap, error_cnt, n_compared, cyc;
   cause_word_t d;

   smi_source_status #(.PERIODIC_BASE_CYC(16)) u_smi_source_status (
      .clk, .reset, .acpiBase, .ioAddr, .ioWrStrobe, .ioRdStrobe, .ioByteEn, .ioWrData, .ioRdData,
      .ioRdValid, .smiEnable, .globalSmiEnable, .endSmiSetPulse, .endOfSmi, .sysMgmtIrqN, .usb3HostSmiReq,
      .engineSmiReq, .serialFlashSmiReq, .trapMonitorReq, .pcieSmiReq, .serialIrqSmiReq,
      .deviceTrapStatus0, .pinSmiReq, .gpeStatus, .gpeEnable, .pm1Status, .legacyKbdStatus,
      .legacyKbdEnable, .espiSmiAssert, .espiSmiDeassert, .pinUnlockSmiReq, .tcoSmiEvent,
      .softTimerExpire, .apmCtrlWrite, .periodicRateSelect, .smbusTargetSmiMsg, .smbusHostNotifyMsg,
      .smbusSmiInS0Msg, .smbusAlertN, .smbusSmiEnable, .smbusAlertDisable, .hostNotifyIrqEnable);
   host_smi_model u_host_smi_model (.clk, .reset, .sysMgmtIrqN, .serviceEn, .endSmiSetPulse, .lowCount,
      .minGap);

   // ========================================
   // shared tasks
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic rds();
      @(negedge clk);
      ioAddr = acpiBase + `CAUSE_STATUS_OFS;
      ioRdStrobe = 1'b1;
      @(negedge clk);
      ioRdStrobe = 1'b0;
      d = ioRdData;
      check("read valid", ioRdValid, 1);
   endtask
   task automatic wr(logic [15:0] a, logic [31:0] v, logic [3:0] be);
      @(negedge clk);
      ioAddr = a;
      ioWrData = v;
      ioByteEn = be;
      ioWrStrobe = 1'b1;
      @(negedge clk);
      ioWrStrobe = 1'b0;
   endtask
   // reads one bit, then writes a one to it, which clears it only if it is a write-1-clear bit
   task automatic expect_clr(int b, logic v);
      rds();
      check($sformatf("status bit %0d", b), d[b], v);
      wr(acpiBase + `CAUSE_STATUS_OFS, 32'h1 << b, 4'hF);
   endtask
   task automatic wait_low();
      for (int i = 0; i < 20 && sysMgmtIrqN !== 1'b0; i++) @(negedge clk);
      check("smi asserted", sysMgmtIrqN, 0);
   endtask

   // ========================================
   // scenarios
   task automatic t_reset();
      rds();
      check("status after reset", d & ~32'h4000, 32'h0);
      check("end of smi after reset", endOfSmi, 1);
      check("smi idle after reset", sysMgmtIrqN, 1);
   endtask
   task automatic t_levels();
      {usb3HostSmiReq, engineSmiReq, serialFlashSmiReq, trapMonitorReq} = 4'hF;
      {pcieSmiReq, serialIrqSmiReq, deviceTrapStatus0, pinSmiReq} = 4'hF;
      wr(acpiBase + `CAUSE_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
      rds();
      check("level bits", d & ~32'h0801_6874, 32'hC430_9400);
      {usb3HostSmiReq, engineSmiReq, serialFlashSmiReq, trapMonitorReq} = 4'h0;
      {pcieSmiReq, serialIrqSmiReq, deviceTrapStatus0, pinSmiReq} = 4'h0;
      rds();
      check("levels released", d & ~32'h4000, 32'h0);
   endtask
   task automatic t_espi();
      pulse(espiSmiAssert);
      expect_clr(`B_ESPI, 1);
      expect_clr(`B_ESPI, 1);
      pulse(espiSmiDeassert);
      expect_clr(`B_ESPI, 0);
   endtask
   task automatic t_sticky();
      pulse(pinUnlockSmiReq);
      pulse(tcoSmiEvent);
      pulse(softTimerExpire);
      pulse(apmCtrlWrite);
      rds();
      check("apm without enable", d[`B_APM], 0);
      smiEnable = 32'h1 << `B_APM;
      pulse(apmCtrlWrite);
      smiEnable = 32'h0;
      wr(acpiBase + `PM1_CTRL_OFS, 32'h0000_2004, 4'h3);
      wr(`MICRO_PORT_HI, 32'h0, 4'h1);
      pulse(smbusTargetSmiMsg);
      rds();
      check("sticky set", d & ~32'h4000, 32'h0801_2874);
      wr(acpiBase + `CAUSE_STATUS_OFS, 32'hFFFF_FFFF, 4'h1);
      rds();
      check("lane 0 cleared", d & ~32'h4000, 32'h0801_2800);
      wr(acpiBase + `CAUSE_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
      rds();
      check("all cleared", d & ~32'h4000, 32'h0);
      wr(`MICRO_PORT_LO, 32'h0, 4'h1);
      expect_clr(`B_MICRO, 1);
   endtask
   task automatic t_midreset();
      pulse(pinUnlockSmiReq);
      pulse(tcoSmiEvent);
      pulse(espiSmiAssert);
      wr(`MICRO_PORT_LO, 32'h0, 4'h1);
      reset = 1'b1;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      rds();
      check("status after mid reset", d & ~32'h4000, 32'h0);
      check("end of smi after mid reset", endOfSmi, 1);
   endtask
   task automatic t_smbus();
      smbusSmiEnable = 1'b1;
      smbusAlertDisable = 1'b1;
      smbusAlertN = 1'b0;
      repeat (4) @(negedge clk);
      smbusAlertN = 1'b1;
      expect_clr(`B_SMBUS, 0);
      smbusAlertDisable = 1'b0;
      smbusAlertN = 1'b0;
      repeat (4) @(negedge clk);
      smbusAlertN = 1'b1;
      expect_clr(`B_SMBUS, 1);
      hostNotifyIrqEnable = 1'b1;
      pulse(smbusHostNotifyMsg);
      expect_clr(`B_SMBUS, 1);
      smbusSmiEnable = 1'b0;
      pulse(smbusSmiInS0Msg);
      expect_clr(`B_SMBUS, 1);
   endtask
   task automatic t_summary();
      gpeStatus = 32'hFFFF_FFFF;
      gpeEnable = ~`GPE_SUMMARY_MASK;
      pm1Status = 16'h0030;
      legacyKbdStatus = 8'hFF;
      rds();
      check("summaries off", {d[10:8], d[3]}, 4'h0);
      gpeEnable = 32'h1 << 8;
      pm1Status = 16'h0001;
      legacyKbdEnable = 8'h80;
      rds();
      check("summaries on", {d[9:8], d[3]}, 3'h7);
   endtask
   task automatic t_periodic();
      for (int s = 0; s < 4; s++) begin
         periodicRateSelect = 2'(s);
         wr(acpiBase + `CAUSE_STATUS_OFS, 32'h1 << `B_PERIODIC, 4'hF);
         repeat ((16 << s) + 3) @(negedge clk);
         expect_clr(`B_PERIODIC, 1);
      end
   endtask
   task automatic t_smi();
      globalSmiEnable = 1'b1;
      smiEnable = 32'h1 << `B_SWTMR;
      serviceEn = 1'b0;
      pulse(softTimerExpire);
      wait_low();
      check("end of smi cleared", endOfSmi, 0);
      repeat (50) @(negedge clk);
      check("smi held until end of smi", sysMgmtIrqN, 0);
      serviceEn = 1'b1;
      repeat (200) @(negedge clk);
      check("smi reasserted", lowCount >= 2, 1);
      check("gap of four pci clocks", minGap >= `SMI_GAP_PCI * `PCI_DIV_CYC, 1);
      wr(acpiBase + `CAUSE_STATUS_OFS, 32'h1 << `B_SWTMR, 4'hF);
      repeat (60) @(negedge clk);
      check("smi idle after clear", sysMgmtIrqN, 1);
      globalSmiEnable = 1'b0;
      pulse(softTimerExpire);
      repeat (40) @(negedge clk);
      check("global disable", sysMgmtIrqN, 1);
      wr(acpiBase + `CAUSE_STATUS_OFS, 32'h1 << `B_SWTMR, 4'hF);
      globalSmiEnable = 1'b1;
      smiEnable = 32'h0000_0700;
      pinSmiReq = 1'b1;
      repeat (40) @(negedge clk);
      check("bits 8 to 10 cause nothing", sysMgmtIrqN, 1);
      smiEnable = 32'h1 << `B_MICRO;
      wr(`MICRO_PORT_LO, 32'h0, 4'h1);
      wait_low();
   endtask

   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ========================================
   // clock, timeout, main sequence
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      {ioWrStrobe, ioRdStrobe, globalSmiEnable, serviceEn, ioAddr, ioByteEn, ioWrData} = '0;
      {smiEnable, gpeStatus, gpeEnable, pm1Status, legacyKbdStatus, legacyKbdEnable} = '0;
      {usb3HostSmiReq, engineSmiReq, serialFlashSmiReq, trapMonitorReq, pcieSmiReq} = '0;
      {serialIrqSmiReq, deviceTrapStatus0, pinSmiReq, espiSmiAssert, espiSmiDeassert} = '0;
      {pinUnlockSmiReq, tcoSmiEvent, softTimerExpire, apmCtrlWrite, periodicRateSelect} = '0;
      {smbusTargetSmiMsg, smbusHostNotifyMsg, smbusSmiInS0Msg, smbusSmiEnable} = '0;
      {smbusAlertDisable, hostNotifyIrqEnable} = '0;
      smbusAlertN = 1'b1;
      acpiBase = 16'h0400;
      reset = 1'b1;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_levels();
      t_espi();
      t_sticky();
      t_midreset();
      t_smbus();
      t_summary();
      t_periodic();
      t_smi();
      final_report();
   end
endmodule
